//--- hw/mcf_regs.svh
// Constants for the machine check frame and acknowledge block
`ifndef MCF_REGS_SVH
`define MCF_REGS_SVH
`define MCF_IPR_ACK 6'h26
`define MCF_CODE_WRITE_ERR 8'h12
`define MCF_CODE_BUS_UNDEF 8'h13
`define MCF_CODE_READ_CACHE 8'h10
`define MCF_CODE_READ_BUS 8'h11
`define MCF_SLOT_CODE 4'h1
`define MCF_SLOT_VADDR 4'h2
`define MCF_SLOT_PREFETCH 4'h3
`define MCF_SLOT_SUMMARY 4'h4
`define MCF_SLOT_STATE 4'h5
`define MCF_SLOT_SHIFT 4'h6
`define MCF_SLOT_PC 4'h7
`define MCF_SLOT_PSW 4'h8
`define MCF_SLOT_LAST 4'h8
`define MCF_SUM_IE_BIT 22
`define MCF_ICLK_IE_BIT 6
`define MCF_FRAME_BYTES 8'h20
`endif

//--- hw/mcf_pkg.sv
// Types shared by the machine check frame block
package mcf_pkg;
    typedef enum logic [2:0] {
        MCF_AT_READ = 3'h0,
        MCF_AT_WRITE = 3'h1,
        MCF_AT_MODIFY = 3'h2,
        MCF_AT_ADDRESS = 3'h5,
        MCF_AT_VARBIT = 3'h6,
        MCF_AT_BRANCH = 3'h7
    } mcf_access_e;
    typedef enum logic [1:0] {
        MCF_DL_BYTE = 2'h0,
        MCF_DL_WORD = 2'h1,
        MCF_DL_LONG = 2'h2,
        MCF_DL_QUAD = 2'h3
    } mcf_length_e;
    typedef logic [31:0] mcf_word_t;
endpackage

//--- hw/mcf_state_pack.sv
// Packs the internal state longword of the machine check frame
`timescale 1ns/100ps
`default_nettype none
module mcf_state_pack (
    input wire logic [31:0] cur_pc,
    input wire logic [31:0] backup_pc,
    input wire logic [2:0] access_type,
    input wire logic [1:0] data_length,
    input wire logic [7:0] opcode,
    input wire logic [3:0] dest_reg_number,
    output logic [31:0] state_word
);
    logic [31:0] delta_pc;
    always_comb begin
        delta_pc = cur_pc - backup_pc;
        state_word = {delta_pc[7:0],
                      3'h0,
                      access_type,
                      data_length,
                      opcode,
                      4'h0,
                      dest_reg_number};
    end
endmodule
`default_nettype wire

//--- hw/mcf_frame.sv
// Machine check frame builder with in-progress flag and acknowledge register
`include "mcf_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module mcf_frame (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic write_bus_err,
    input wire logic bus_undef_state,
    input wire logic read_err,
    input wire logic [7:0] read_err_code,
    input wire logic other_check,
    input wire logic [7:0] other_check_code,
    input wire logic mm_exception,
    input wire logic [31:0] virtual_address_capture,
    input wire logic [31:0] prefetch_address_pointer,
    input wire logic [31:0] interval_clock_ctrl,
    input wire logic [15:0] soft_irq_summary,
    input wire logic [31:0] cur_pc,
    input wire logic [31:0] backup_pc,
    input wire logic [2:0] access_type,
    input wire logic [1:0] data_length,
    input wire logic [7:0] opcode,
    input wire logic [3:0] dest_reg_number,
    input wire logic [31:0] shift_count,
    input wire logic [31:0] inst_start_pc,
    input wire logic [31:0] processor_status_word,
    input wire logic [31:0] sp_base,
    input wire logic ipr_wr,
    input wire logic [5:0] ipr_num,
    input wire logic [31:0] ipr_wdata,
    input wire logic push_ready,
    output logic push_valid,
    output logic [31:0] push_addr,
    output logic [31:0] push_data,
    output logic machine_check_abort,
    output logic [7:0] check_code,
    output logic check_in_progress,
    output logic double_error_halt,
    output logic frame_done
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {MCF_IDLE, MCF_PUSH, MCF_HALT} mcf_state_e;
    mcf_state_e state_reg, state_next;
    logic [3:0] slot_reg, slot_next;
    logic [7:0] code_reg, code_next;
    mcf_pkg::mcf_word_t snap_reg [1:8];
    mcf_pkg::mcf_word_t snap_next [1:8];
    logic [31:0] sp_reg, sp_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [31:0] state_word;
    logic check_any;
    logic [7:0] code_sel;
    logic ack_wr;
    ////////////////////////////////////////////////////////////////////////
    mcf_state_pack u_pack (
        .cur_pc(cur_pc),
        .backup_pc(backup_pc),
        .access_type(access_type),
        .data_length(data_length),
        .opcode(opcode),
        .dest_reg_number(dest_reg_number),
        .state_word(state_word)
    );
    // Data is ignored; any write to IPR 6'h26 acknowledges, but only in the idle state
    assign ack_wr = ipr_wr && (ipr_num == `MCF_IPR_ACK);
    assign check_any = write_bus_err || bus_undef_state || read_err || other_check;
    // Bus undefined outranks a write error; both outrank the rest
    always_comb begin
        if (bus_undef_state) begin
            code_sel = `MCF_CODE_BUS_UNDEF;
        end else if (write_bus_err) begin
            code_sel = `MCF_CODE_WRITE_ERR;
        end else if (read_err) begin
            code_sel = read_err_code;
        end else begin
            code_sel = other_check_code;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        slot_next = slot_reg;
        code_next = code_reg;
        sp_next = sp_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        for (int i = 1; i <= 8; i++) begin
            snap_next[i] = snap_reg[i];
        end
        unique case (state_reg)
            MCF_IDLE: begin
                if (ack_wr) begin
                    busy_next = 1'b0;
                end
                if ((check_any || mm_exception) && busy_reg && !ack_wr) begin
                    state_next = MCF_HALT;
                end else if (check_any) begin
                    state_next = MCF_PUSH;
                    slot_next = `MCF_SLOT_CODE;
                    code_next = code_sel;
                    sp_next = sp_base;
                    snap_next[`MCF_SLOT_CODE] = {24'h0, code_sel};
                    snap_next[`MCF_SLOT_VADDR] = virtual_address_capture;
                    snap_next[`MCF_SLOT_PREFETCH] = prefetch_address_pointer;
                    snap_next[`MCF_SLOT_SUMMARY] = {9'h0,
                        interval_clock_ctrl[`MCF_ICLK_IE_BIT],
                        6'h0, soft_irq_summary};
                    snap_next[`MCF_SLOT_STATE] = state_word;
                    snap_next[`MCF_SLOT_SHIFT] = shift_count;
                    snap_next[`MCF_SLOT_PC] = inst_start_pc;
                    snap_next[`MCF_SLOT_PSW] = processor_status_word;
                end
            end
            MCF_PUSH: begin
                if (push_ready) begin
                    if (slot_reg == `MCF_SLOT_LAST) begin
                        state_next = MCF_IDLE;
                        busy_next = 1'b1;
                        done_next = 1'b1;
                    end else begin
                        slot_next = slot_reg + 4'h1;
                    end
                end
            end
            MCF_HALT: begin
                state_next = MCF_HALT;
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= MCF_IDLE;
            slot_reg <= 4'h0;
            code_reg <= 8'h0;
            sp_reg <= 32'h0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            for (int i = 1; i <= 8; i++) begin
                snap_reg[i] <= 32'h0;
            end
        end else begin
            state_reg <= state_next;
            slot_reg <= slot_next;
            code_reg <= code_next;
            sp_reg <= sp_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            for (int i = 1; i <= 8; i++) begin
                snap_reg[i] <= snap_next[i];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] slot_offset(input logic [3:0] slot);
        return {26'h0, slot, 2'h0};
    endfunction
    // Slot n lands at SP+4n: code at SP+4, address at SP+8, status word at SP+32
    always_comb begin
        push_valid = (state_reg == MCF_PUSH);
        push_addr = sp_reg + slot_offset(slot_reg);
        push_data = (state_reg == MCF_PUSH) ? snap_reg[slot_reg] : 32'h0;
        machine_check_abort = (state_reg == MCF_PUSH);
        check_code = code_reg;
        check_in_progress = busy_reg;
        double_error_halt = (state_reg == MCF_HALT);
        frame_done = done_reg;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_write_code;
        @(posedge clk_sys) disable iff (sys_rst)
        (state_reg == MCF_IDLE && !busy_reg && write_bus_err && !bus_undef_state)
            |=> (check_code == `MCF_CODE_WRITE_ERR);
    endproperty
    a_write_code: assert property (p_write_code) else $error("write error code wrong");
    property p_undef_code;
        @(posedge clk_sys) disable iff (sys_rst)
        (state_reg == MCF_IDLE && !busy_reg && bus_undef_state)
            |=> (check_code == `MCF_CODE_BUS_UNDEF);
    endproperty
    a_undef_code: assert property (p_undef_code) else $error("bus state code wrong");
    property p_vaddr_slot;
        @(posedge clk_sys) disable iff (sys_rst)
        (push_valid && slot_reg == `MCF_SLOT_VADDR)
            |-> (push_addr == sp_reg + 32'h8);
    endproperty
    a_vaddr_slot: assert property (p_vaddr_slot) else $error("address slot offset wrong");
    property p_psw_slot;
        @(posedge clk_sys) disable iff (sys_rst)
        (push_valid && slot_reg == `MCF_SLOT_PSW) |-> (push_addr == sp_reg + 32'h20);
    endproperty
    a_psw_slot: assert property (p_psw_slot) else $error("status slot offset wrong");
    property p_state_zero;
        @(posedge clk_sys) disable iff (sys_rst)
        1'b1 |-> (state_word[23] == 1'b0 && state_word[21] == 1'b0 && state_word[7:4] == 4'h0);
    endproperty
    a_state_zero: assert property (p_state_zero) else $error("unused state bits set");
    property p_busy_set;
        @(posedge clk_sys) disable iff (sys_rst)
        (push_valid && push_ready && slot_reg == `MCF_SLOT_LAST) |=> check_in_progress;
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("in-progress not set");
    property p_halt;
        @(posedge clk_sys) disable iff (sys_rst)
        (state_reg == MCF_IDLE && busy_reg && !ack_wr && (check_any || mm_exception))
            |=> double_error_halt [*2];
    endproperty
    a_halt: assert property (p_halt) else $error("double error not halted");
    property p_ack;
        @(posedge clk_sys) disable iff (sys_rst)
        (state_reg == MCF_IDLE && ack_wr) |=> !check_in_progress;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge did not clear");
    property p_prefetch_slot;
        @(posedge clk_sys) disable iff (sys_rst)
        (push_valid && slot_reg == `MCF_SLOT_PREFETCH) |-> (push_addr == sp_reg + 32'hc);
    endproperty
    a_prefetch_slot: assert property (p_prefetch_slot) else $error("prefetch slot bad");
    property p_summary_slot;
        @(posedge clk_sys) disable iff (sys_rst)
        (push_valid && slot_reg == `MCF_SLOT_SUMMARY)
            |-> (push_addr == sp_reg + 32'h10 && push_data[31:23] == 9'h0
                && push_data[21:16] == 6'h0);
    endproperty
    a_summary_slot: assert property (p_summary_slot) else $error("summary bad");
    property p_state_slot;
        @(posedge clk_sys) disable iff (sys_rst)
        (push_valid && slot_reg == `MCF_SLOT_STATE) |-> (push_addr == sp_reg + 32'h14);
    endproperty
    a_state_slot: assert property (p_state_slot) else $error("state slot bad");
    property p_shift_slot;
        @(posedge clk_sys) disable iff (sys_rst)
        (push_valid && slot_reg == `MCF_SLOT_SHIFT) |-> (push_addr == sp_reg + 32'h18);
    endproperty
    a_shift_slot: assert property (p_shift_slot) else $error("shift slot bad");
    property p_pc_slot;
        @(posedge clk_sys) disable iff (sys_rst)
        (push_valid && slot_reg == `MCF_SLOT_PC) |-> (push_addr == sp_reg + 32'h1c);
    endproperty
    a_pc_slot: assert property (p_pc_slot) else $error("pc slot bad");
    property p_read_code;
        @(posedge clk_sys) disable iff (sys_rst)
        (state_reg == MCF_IDLE && (!busy_reg || ack_wr) && read_err && !write_bus_err
            && !bus_undef_state) |=> (check_code == $past(read_err_code));
    endproperty
    a_read_code: assert property (p_read_code) else $error("read code bad");
    // The snapshot is taken on the check edge; later input changes must not leak in
    property p_sum_capture;
        @(posedge clk_sys) disable iff (sys_rst)
        (state_reg == MCF_IDLE && (!busy_reg || ack_wr) && check_any)
            |=> (snap_reg[`MCF_SLOT_SUMMARY][`MCF_SUM_IE_BIT]
                == $past(interval_clock_ctrl[`MCF_ICLK_IE_BIT])
                && snap_reg[`MCF_SLOT_SUMMARY][15:0] == $past(soft_irq_summary));
    endproperty
    a_sum_capture: assert property (p_sum_capture) else $error("capture bad");
    // Only the low byte of the PC difference fits the field
    property p_delta_pc;
        @(posedge clk_sys) disable iff (sys_rst)
        1'b1 |-> (state_word[31:24] == 8'(cur_pc - backup_pc));
    endproperty
    a_delta_pc: assert property (p_delta_pc) else $error("delta pc bad");
    property p_state_type;
        @(posedge clk_sys) disable iff (sys_rst)
        1'b1 |-> (state_word[20:18] == access_type && state_word[17:16] == data_length);
    endproperty
    a_state_type: assert property (p_state_type) else $error("type bad");
    property p_state_ops;
        @(posedge clk_sys) disable iff (sys_rst)
        1'b1 |-> (state_word[15:8] == opcode && state_word[3:0] == dest_reg_number);
    endproperty
    a_state_ops: assert property (p_state_ops) else $error("opcode bad");
    // A stalled word must stand or the stack writer could store a mix of two slots
    property p_stall_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        (push_valid && !push_ready)
            |=> (push_valid && $stable(push_addr) && $stable(push_data));
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("stall not held");
    property p_done_pulse;
        @(posedge clk_sys) disable iff (sys_rst)
        frame_done |=> !frame_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_halt_sticky;
        @(posedge clk_sys) disable iff (sys_rst)
        double_error_halt |=> double_error_halt;
    endproperty
    a_halt_sticky: assert property (p_halt_sticky) else $error("halt left");
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the machine check frame builder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_sys, sys_rst, write_bus_err, bus_undef_state, read_err, other_check, mm_exception;
    logic [7:0] read_err_code, other_check_code, opcode, check_code;
    logic [31:0] virtual_address_capture, prefetch_address_pointer, interval_clock_ctrl;
    logic [15:0] soft_irq_summary;
    logic [31:0] cur_pc, backup_pc, shift_count, inst_start_pc, processor_status_word, sp_base;
    logic [2:0] access_type;
    logic [1:0] data_length;
    logic [3:0] dest_reg_number;
    logic ipr_wr, push_ready, push_valid, machine_check_abort, check_in_progress;
    logic double_error_halt, frame_done;
    logic [5:0] ipr_num;
    logic [31:0] ipr_wdata, push_addr, push_data;
    int miscompares = 0;
    int checks_done = 0;
    logic [2:0] ats [6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};

    mcf_frame u_dut (.clk_sys, .sys_rst, .write_bus_err, .bus_undef_state, .read_err,
        .read_err_code, .other_check, .other_check_code, .mm_exception, .virtual_address_capture,
        .prefetch_address_pointer, .interval_clock_ctrl, .soft_irq_summary, .cur_pc, .backup_pc,
        .access_type, .data_length, .opcode, .dest_reg_number, .shift_count, .inst_start_pc,
        .processor_status_word, .sp_base, .ipr_wr, .ipr_num, .ipr_wdata, .push_ready, .push_valid,
        .push_addr, .push_data, .machine_check_abort, .check_code, .check_in_progress,
        .double_error_halt, .frame_done);

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Fields vary with the access type so slot mix-ups show as wrong data
    task automatic run_frame(input int kind, input logic [2:0] at, input logic [1:0] dl);
        logic [31:0] exp [8];
        logic [31:0] b, d;
        int n, t;
        b = {24'h0, at, dl, 3'h0};
        d = 32'h34 + b;
        exp = '{{24'h0, kind == 0 ? 8'h12 : kind == 1 ? 8'h13 : kind == 2 ? 8'h10 : 8'h11},
            32'ha000_0000 | b, 32'hb000_0004 | b, {9'h0, at[0], 6'h0, 16'hf00f ^ b[15:0]},
            {d[7:0], 3'h0, at, dl, 8'h9c ^ b[7:0], 4'h0, dl, at[1:0]},
            32'hc000_0000 | b, 32'hd000_0000 | b, 32'h041f_0000 | b};
        @(posedge clk_sys);
        // Write errors are injected on purpose; a sound bus side never causes one
        {write_bus_err, bus_undef_state, read_err} <= 3'b100 >> (kind > 2 ? 2 : kind);
        read_err_code <= kind == 3 ? 8'h11 : 8'h10;
        virtual_address_capture <= exp[1];
        prefetch_address_pointer <= exp[2];
        // Other control bits set whenever bit 6 is clear, so only bit 6 may reach the summary word
        interval_clock_ctrl <= at[0] ? 32'h0000_0040 : 32'hffff_ffbf;
        soft_irq_summary <= exp[3][15:0];
        cur_pc <= 32'h0000_1234 + b;
        backup_pc <= 32'h0000_1200;
        access_type <= at;
        data_length <= dl;
        opcode <= 8'h9c ^ b[7:0];
        dest_reg_number <= {dl, at[1:0]};
        shift_count <= exp[5];
        inst_start_pc <= exp[6];
        processor_status_word <= exp[7];
        @(posedge clk_sys);
        {write_bus_err, bus_undef_state, read_err} <= 3'b000;
        n = 0;
        t = 0;
        // Ready toggles so every word must stand through a stall
        while (n < 8 && t < 100) begin
            @(negedge clk_sys);
            check("abort", machine_check_abort, push_valid);
            if (push_valid === 1'b1 && push_ready === 1'b1) begin
                check("push_addr", push_addr, sp_base + 32'(4 * (n + 1)));
                check("push_data", push_data, exp[n]);
                n++;
            end
            @(posedge clk_sys);
            push_ready <= ~push_ready;
            t++;
        end
        check("words", 32'(n), 32'd8);
        t = 0;
        @(negedge clk_sys);
        while (frame_done !== 1'b1 && t < 5) begin
            @(negedge clk_sys);
            t++;
        end
        check("frame_done", frame_done, 1'b1);
        check("check_code", check_code, exp[0]);
        check("in_progress", check_in_progress, 1'b1);
        check("halt", double_error_halt, 1'b0);
    endtask

    task automatic ack(input logic [5:0] num);
        @(posedge clk_sys);
        ipr_wr <= 1'b1;
        ipr_num <= num;
        @(posedge clk_sys);
        ipr_wr <= 1'b0;
        @(negedge clk_sys);
        check("in_progress", check_in_progress, num != 6'h26);
    endtask

    task automatic double_err(input logic use_mm);
        @(posedge clk_sys);
        {mm_exception, other_check} <= use_mm ? 2'b10 : 2'b01;
        @(posedge clk_sys);
        {mm_exception, other_check} <= 2'b00;
        repeat (3) @(negedge clk_sys);
        check("halt", double_error_halt, 1'b1);
        check("no_frame", push_valid, 1'b0);
        ack(6'h25);
        check("halt", double_error_halt, 1'b1);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        check("halt", double_error_halt, 1'b0);
        check("rst_busy", check_in_progress, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_rst, write_bus_err, bus_undef_state, read_err, other_check, mm_exception} = 6'h20;
        {read_err_code, other_check_code, opcode, access_type, data_length} = '0;
        {virtual_address_capture, prefetch_address_pointer, interval_clock_ctrl} = '0;
        {soft_irq_summary, cur_pc, backup_pc, dest_reg_number, shift_count} = '0;
        {inst_start_pc, processor_status_word, ipr_wr, ipr_num, ipr_wdata} = '0;
        sp_base = 32'h0000_7f00;
        push_ready = 1'b0;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        check("idle", {push_valid, check_in_progress, double_error_halt, frame_done}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            run_frame(i % 4, ats[i], 2'(i));
            if (i == 0) begin
                ack(6'h25);
            end
            ack(6'h26);
        end
        run_frame(0, 3'h7, 2'h3);
        double_err(1'b0);
        run_frame(1, 3'h1, 2'h0);
        double_err(1'b1);
        final_report();
    end

    initial begin
        #(40 * 5000);
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
